/* File: rtl/pgpc_pin.sv */
`timescale 1ns/1ps
`default_nettype none
module pgpc_pin #(
    parameter int LONG_CYC = pgpc_pkg::PGPC_LONG_DB_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // register port
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // pin
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_o,
    output logic pull_up_o,
    output logic pull_down_o,
    output logic supply_domain_select_o,
    // internal sources for output functions
    input wire logic clk_32k_i,
    input wire logic on_state_i,
    input wire logic sleep_state_i,
    input wire logic state_change_i,
    input wire logic vscale1_done_i,
    input wire logic vscale2_done_i,
    input wire logic ext_pwr_en1_i,
    input wire logic ext_pwr_en2_i,
    input wire logic system_supply_good_i,
    input wire logic converter_power_good_i,
    input wire logic clk_2m_i,
    input wire logic aux_reset_i,
    // input function requests
    output logic gpio_level_o,
    output logic onoff_req_o,
    output logic sleepwake_req_o,
    output logic sleep_req_o,
    output logic pwron_req_o,
    output logic wdog_reset_o,
    output logic voltage_scale_select_one_o,
    output logic voltage_scale_select_two_o,
    output logic hw_enable1_o,
    output logic hw_enable2_o,
    output logic hw_control1_o,
    output logic hw_control2_o,
    // interrupt
    output logic irq_o
);
    logic [15:0] cfg_reg;
    logic [1:0] stat_reg;
    logic [1:0] mask_reg;
    logic dout_reg;
    logic filt;
    logic filt_d_reg;
    logic logical_in;
    logic logical_d;
    logic is_input;
    logic [3:0] fn;
    logic long_db;
    logic rise;
    logic fall;
    logic edge_ev;
    logic req_ev;
    logic src_level;
    logic drive_val;
    logic [15:0] rd_mux;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] off);
        addr_hit = (a == off);
    endfunction : addr_hit

    function automatic logic pol_apply(input logic pol, input logic lvl);
        pol_apply = pol ? lvl : ~lvl;
    endfunction : pol_apply

    assign is_input = cfg_reg[pgpc_pkg::PGPC_DIR_BIT];
    assign fn = cfg_reg[pgpc_pkg::PGPC_FN_HI:0];
    assign long_db = (fn == pgpc_pkg::PGPC_IN_GPIO_LONG)
        || (fn == pgpc_pkg::PGPC_IN_SLEEPWAKE_LONG)
        || (fn == pgpc_pkg::PGPC_IN_HWCTL1_LONG)
        || (fn == pgpc_pkg::PGPC_IN_HWCTL2_LONG);

    // ------------------------------------------------------------
    // input path
    // ------------------------------------------------------------
    pgpc_debounce #(
        .LONG_CYC(LONG_CYC)
    ) u_db (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .long_i(long_db),
        .raw_i(pin_i),
        .level_o(filt)
    );

    // polarity gives the logical level
    assign logical_in = pol_apply(cfg_reg[pgpc_pkg::PGPC_POL_BIT], filt);
    assign logical_d = pol_apply(cfg_reg[pgpc_pkg::PGPC_POL_BIT], filt_d_reg);
    assign rise = filt & ~filt_d_reg;
    assign fall = ~filt & filt_d_reg;
    assign edge_ev = is_input && cfg_reg[pgpc_pkg::PGPC_ENA_BIT]
        && (cfg_reg[pgpc_pkg::PGPC_EDGE_BIT] ? (rise | fall)
            : (cfg_reg[pgpc_pkg::PGPC_POL_BIT] ? rise : fall));
    assign req_ev = is_input && cfg_reg[pgpc_pkg::PGPC_ENA_BIT] && logical_in && !logical_d
        && (fn >= pgpc_pkg::PGPC_IN_ONOFF) && (fn <= pgpc_pkg::PGPC_IN_PWRON);

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            filt_d_reg <= 1'b0;
        end else if (clk_en_i) begin
            filt_d_reg <= filt;
        end
    end

    // ------------------------------------------------------------
    // input function routing
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gpio_level_o <= 1'b0;
            onoff_req_o <= 1'b0;
            sleepwake_req_o <= 1'b0;
            sleep_req_o <= 1'b0;
            pwron_req_o <= 1'b0;
            wdog_reset_o <= 1'b0;
            voltage_scale_select_one_o <= 1'b0;
            voltage_scale_select_two_o <= 1'b0;
            hw_enable1_o <= 1'b0;
            hw_enable2_o <= 1'b0;
            hw_control1_o <= 1'b0;
            hw_control2_o <= 1'b0;
        end else if (clk_en_i) begin
            gpio_level_o <= logical_in;
            onoff_req_o <= 1'b0;
            sleepwake_req_o <= 1'b0;
            sleep_req_o <= 1'b0;
            pwron_req_o <= 1'b0;
            wdog_reset_o <= 1'b0;
            voltage_scale_select_one_o <= 1'b0;
            voltage_scale_select_two_o <= 1'b0;
            hw_enable1_o <= 1'b0;
            hw_enable2_o <= 1'b0;
            hw_control1_o <= 1'b0;
            hw_control2_o <= 1'b0;
            if (is_input && cfg_reg[pgpc_pkg::PGPC_ENA_BIT]) begin
                case (fn)
                    pgpc_pkg::PGPC_IN_ONOFF: onoff_req_o <= logical_in;
                    pgpc_pkg::PGPC_IN_SLEEPWAKE,
                    pgpc_pkg::PGPC_IN_SLEEPWAKE_LONG: sleepwake_req_o <= logical_in;
                    pgpc_pkg::PGPC_IN_SLEEP: sleep_req_o <= logical_in;
                    pgpc_pkg::PGPC_IN_PWRON: pwron_req_o <= logical_in;
                    pgpc_pkg::PGPC_IN_WDOG: wdog_reset_o <= logical_in;
                    pgpc_pkg::PGPC_IN_VSCALE1: voltage_scale_select_one_o <= logical_in;
                    pgpc_pkg::PGPC_IN_VSCALE2: voltage_scale_select_two_o <= logical_in;
                    pgpc_pkg::PGPC_IN_HWEN1: hw_enable1_o <= logical_in;
                    pgpc_pkg::PGPC_IN_HWEN2: hw_enable2_o <= logical_in;
                    pgpc_pkg::PGPC_IN_HWCTL1,
                    pgpc_pkg::PGPC_IN_HWCTL1_LONG: hw_control1_o <= logical_in;
                    pgpc_pkg::PGPC_IN_HWCTL2,
                    pgpc_pkg::PGPC_IN_HWCTL2_LONG: hw_control2_o <= logical_in;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // output function select
    // ------------------------------------------------------------
    always_comb begin
        case (fn)
            4'h0: src_level = dout_reg;
            4'h1: src_level = clk_32k_i;
            4'h2: src_level = on_state_i;
            4'h3: src_level = sleep_state_i;
            4'h4: src_level = state_change_i;
            4'h8: src_level = vscale1_done_i;
            4'h9: src_level = vscale2_done_i;
            4'ha: src_level = ext_pwr_en1_i;
            4'hb: src_level = ext_pwr_en2_i;
            4'hc: src_level = system_supply_good_i;
            4'hd: src_level = converter_power_good_i;
            4'he: src_level = clk_2m_i;
            4'hf: src_level = aux_reset_i;
            default: src_level = 1'b0;
        endcase
        drive_val = pol_apply(cfg_reg[pgpc_pkg::PGPC_POL_BIT], src_level);
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0;
            pull_up_o <= 1'b0;
            pull_down_o <= 1'b0;
            supply_domain_select_o <= 1'b0;
        end else if (clk_en_i) begin
            supply_domain_select_o <= cfg_reg[pgpc_pkg::PGPC_DOM_BIT];
            pull_up_o <= cfg_reg[pgpc_pkg::PGPC_ENA_BIT]
                && (cfg_reg[pgpc_pkg::PGPC_PULL_HI:pgpc_pkg::PGPC_PULL_LO] == pgpc_pkg::PGPC_PULL_UP);
            pull_down_o <= cfg_reg[pgpc_pkg::PGPC_ENA_BIT]
                && (cfg_reg[pgpc_pkg::PGPC_PULL_HI:pgpc_pkg::PGPC_PULL_LO] == pgpc_pkg::PGPC_PULL_DOWN);
            if (!cfg_reg[pgpc_pkg::PGPC_ENA_BIT] || is_input) begin
                pin_o <= 1'b0;
                pin_oe_o <= 1'b0;
            end else if (cfg_reg[pgpc_pkg::PGPC_OD_BIT]) begin
                pin_o <= 1'b0;
                pin_oe_o <= ~drive_val;
            end else begin
                pin_o <= drive_val;
                pin_oe_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_reg <= pgpc_pkg::PGPC_CFG_RESET;
            mask_reg <= 2'h0;
            dout_reg <= 1'b0;
        end else if (clk_en_i && wr_i) begin
            if (addr_hit(addr_i, pgpc_pkg::PGPC_CFG_OFFSET)) begin
                cfg_reg <= wdata_i & pgpc_pkg::PGPC_CFG_WMASK;
            end
            if (addr_hit(addr_i, pgpc_pkg::PGPC_MASK_OFFSET)) begin
                mask_reg <= wdata_i[1:0];
            end
            if (addr_hit(addr_i, pgpc_pkg::PGPC_DOUT_OFFSET)) begin
                dout_reg <= wdata_i[0];
            end
        end
    end

    // sticky status, set beats clear
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stat_reg <= 2'h0;
        end else if (clk_en_i) begin
            if (wr_i && addr_hit(addr_i, pgpc_pkg::PGPC_STAT_OFFSET)) begin
                stat_reg[pgpc_pkg::PGPC_ST_EDGE] <= edge_ev
                    | (stat_reg[pgpc_pkg::PGPC_ST_EDGE] & ~wdata_i[pgpc_pkg::PGPC_ST_EDGE]);
                stat_reg[pgpc_pkg::PGPC_ST_REQ] <= req_ev
                    | (stat_reg[pgpc_pkg::PGPC_ST_REQ] & ~wdata_i[pgpc_pkg::PGPC_ST_REQ]);
            end else begin
                stat_reg <= stat_reg | {req_ev, edge_ev};
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else if (clk_en_i) begin
            irq_o <= |(stat_reg & mask_reg);
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 16'h0;
        if (addr_hit(addr_i, pgpc_pkg::PGPC_CFG_OFFSET)) begin
            rd_mux = cfg_reg;
        end else if (addr_hit(addr_i, pgpc_pkg::PGPC_STAT_OFFSET)) begin
            rd_mux = {14'h0, stat_reg};
        end else if (addr_hit(addr_i, pgpc_pkg::PGPC_MASK_OFFSET)) begin
            rd_mux = {14'h0, mask_reg};
        end else if (addr_hit(addr_i, pgpc_pkg::PGPC_DOUT_OFFSET)) begin
            rd_mux = {14'h0, gpio_level_o, dout_reg};
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 16'h0;
        end else if (clk_en_i) begin
            rdata_o <= rd_i ? rd_mux : 16'h0;
        end
    end
endmodule : pgpc_pin
`default_nettype wire

/* File: rtl/pgpc_pkg.sv */
package pgpc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] PGPC_CFG_OFFSET = 16'h403c;
    localparam logic [15:0] PGPC_STAT_OFFSET = 16'h4040;
    localparam logic [15:0] PGPC_MASK_OFFSET = 16'h4041;
    localparam logic [15:0] PGPC_DOUT_OFFSET = 16'h4042;
    localparam logic [15:0] PGPC_CFG_RESET = 16'ha400;
    localparam logic [15:0] PGPC_CFG_WMASK = 16'hfe8f;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PGPC_DIR_BIT = 15;
    localparam int PGPC_PULL_HI = 14;
    localparam int PGPC_PULL_LO = 13;
    localparam int PGPC_EDGE_BIT = 12;
    localparam int PGPC_DOM_BIT = 11;
    localparam int PGPC_POL_BIT = 10;
    localparam int PGPC_OD_BIT = 9;
    localparam int PGPC_ENA_BIT = 7;
    localparam int PGPC_FN_HI = 3;
    // status bits
    localparam int PGPC_ST_EDGE = 0;
    localparam int PGPC_ST_REQ = 1;
    // ------------------------------------------------------------
    // debounce timing
    // ------------------------------------------------------------
    localparam int PGPC_CLK_MHZ = 250;
    localparam int PGPC_SHORT_DB_NS = 40;
    localparam int PGPC_SHORT_DB_CYC = (PGPC_SHORT_DB_NS * PGPC_CLK_MHZ + 999) / 1000;
    localparam int PGPC_LONG_DB_US = 1000;
    localparam int PGPC_LONG_DB_CYC = PGPC_LONG_DB_US * PGPC_CLK_MHZ;
    // ------------------------------------------------------------
    // pull codes and functions
    // ------------------------------------------------------------
    localparam logic [1:0] PGPC_PULL_NONE = 2'h0;
    localparam logic [1:0] PGPC_PULL_DOWN = 2'h1;
    localparam logic [1:0] PGPC_PULL_UP = 2'h2;
    typedef enum logic [3:0] {
        PGPC_IN_GPIO_LONG, PGPC_IN_GPIO, PGPC_IN_ONOFF, PGPC_IN_SLEEPWAKE,
        PGPC_IN_SLEEPWAKE_LONG, PGPC_IN_SLEEP, PGPC_IN_PWRON, PGPC_IN_WDOG,
        PGPC_IN_VSCALE1, PGPC_IN_VSCALE2, PGPC_IN_HWEN1, PGPC_IN_HWEN2,
        PGPC_IN_HWCTL1, PGPC_IN_HWCTL2, PGPC_IN_HWCTL1_LONG, PGPC_IN_HWCTL2_LONG
    } pgpc_in_fn_t;
endpackage : pgpc_pkg

/* File: rtl/pgpc_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
module pgpc_debounce #(
    parameter int LONG_CYC = pgpc_pkg::PGPC_LONG_DB_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // control
    input wire logic long_i,
    input wire logic raw_i,
    // filtered level
    output logic level_o
);
    logic [31:0] cnt_reg;
    logic [31:0] limit;

    assign limit = long_i ? 32'(LONG_CYC) : 32'(pgpc_pkg::PGPC_SHORT_DB_CYC);

    // ------------------------------------------------------------
    // stable-count filter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= 32'h0;
            level_o <= 1'b0;
        end else if (clk_en_i) begin
            if (raw_i == level_o) begin
                cnt_reg <= 32'h0;
            end else if (cnt_reg + 32'h1 >= limit) begin
                cnt_reg <= 32'h0;
                level_o <= raw_i;
            end else begin
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end
endmodule : pgpc_debounce
`default_nettype wire

/* File: bench/pgpc_pin_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module pgpc_pin_checker (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // register port
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    // pin and interrupt
    input wire logic pin_o,
    input wire logic pin_oe_o,
    input wire logic pull_up_o,
    input wire logic pull_down_o,
    input wire logic supply_domain_select_o,
    input wire logic irq_o
);
    // ------
    // shadow registers
    // ------
    logic [15:0] cfg_reg;
    logic [1:0] mask_reg;
    logic dout_reg;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) cfg_reg <= 16'ha400;
        else if (clk_en_i && wr_i && addr_i == 16'h403c) cfg_reg <= wdata_i & 16'hfe8f;
    end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) mask_reg <= 2'h0;
        else if (clk_en_i && wr_i && addr_i == 16'h4041) mask_reg <= wdata_i[1:0];
    end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) dout_reg <= 1'b0;
        else if (clk_en_i && wr_i && addr_i == 16'h4042) dout_reg <= wdata_i[0];
    end
    // ------
    // assertions
    // ------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read slot");
    AST_RD_CFG: assert property ($past(rd_i && addr_i == 16'h403c) |-> rdata_o == $past(cfg_reg))
        else $error("config readback differs");
    AST_RD_RSVD: assert property ($past(rd_i) |-> (rdata_o & 16'h0170) == 16'h0000)
        else $error("undefined bits read nonzero");
    AST_TRI: assert property (!$past(cfg_reg[7]) |-> !pin_oe_o && !pull_up_o && !pull_down_o)
        else $error("disabled pin not tri-stated");
    AST_DIR_IN: assert property ($past(cfg_reg[15]) |-> !pin_oe_o)
        else $error("input pin driven");
    AST_PULL_UP: assert property ($past(cfg_reg[7]) && $past(cfg_reg[14:13]) == 2'h2
        |-> pull_up_o && !pull_down_o)
        else $error("pull-up not applied");
    AST_DOMAIN: assert property (supply_domain_select_o == $past(cfg_reg[11]))
        else $error("supply select mismatch");
    AST_OD: assert property ($past(cfg_reg[9]) |-> !pin_o)
        else $error("open drain drove high");
    AST_SW_OUT: assert property ($past(cfg_reg & 16'h828f) == 16'h0080
        |-> pin_oe_o && pin_o == ($past(dout_reg) ~^ $past(cfg_reg[10])))
        else $error("software output level wrong");
    AST_IRQ_MASK: assert property ($past(mask_reg) == 2'h0 |-> !irq_o)
        else $error("masked interrupt raised");
endmodule : pgpc_pin_checker
bind pgpc_pin pgpc_pin_checker pgpc_pin_checker_i (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .clk_en_i(clk_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o),
    .pull_down_o(pull_down_o), .supply_domain_select_o(supply_domain_select_o),
    .irq_o(irq_o));
`default_nettype wire

/* File: bench/pgpc_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module pgpc_far_end (
    // clock and commands
    input wire logic sys_clk_i,
    input wire logic drv_en_i,
    input wire logic drv_val_i,
    // device side of the pin
    input wire logic pin_o,
    input wire logic pin_oe_o,
    input wire logic pull_up_o,
    input wire logic pull_down_o,
    output logic pin_i
);
    // ------
    // wire resolution
    // ------
    // floating pin flips every cycle
    logic last_reg = 1'b0;
    always @(posedge sys_clk_i) last_reg <= pin_i;
    always_comb begin
        if (pin_oe_o) pin_i = pin_o;
        else if (drv_en_i) pin_i = drv_val_i;
        else if (pull_up_o) pin_i = 1'b1;
        else if (pull_down_o) pin_i = 1'b0;
        else pin_i = ~last_reg;
    end
endmodule : pgpc_far_end
`default_nettype wire

/* File: bench/tb_pgpc_pin.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
    $display("wrong value at %0t: got %h exp %h", $time, got, exp); end end
module tb_pgpc_pin;
    // ------
    // signals
    // ------
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [15:0] addr_i = 16'h0;
    logic [15:0] wdata_i = 16'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic pin_i, pin_o, pin_oe_o, pull_up_o, pull_down_o, dom, gpio, irq_o;
    logic [15:0] src = 16'h0;
    wire logic [10:0] reqs;
    logic clk_en = 1'b1;
    logic drv_en = 1'b0;
    logic drv_val = 1'b0;
    logic [3:0] cur = 4'h0;
    int err_total = 0;
    int n_tests = 0;
    localparam int RIDX [16] = '{-1, -1, 0, 1, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 9, 10};
    wire logic [11:0] obs = {(cur < 4'h2) & gpio, reqs};
    always #2 sys_clk_i = ~sys_clk_i;
    pgpc_pin #(.LONG_CYC(40)) pgpc_pin_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .clk_en_i(clk_en), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .pull_up_o(pull_up_o), .pull_down_o(pull_down_o), .supply_domain_select_o(dom),
        .clk_32k_i(src[1]), .on_state_i(src[2]), .sleep_state_i(src[3]),
        .state_change_i(src[4]), .vscale1_done_i(src[8]), .vscale2_done_i(src[9]),
        .ext_pwr_en1_i(src[10]), .ext_pwr_en2_i(src[11]), .system_supply_good_i(src[12]),
        .converter_power_good_i(src[13]), .clk_2m_i(src[14]), .aux_reset_i(src[15]),
        .gpio_level_o(gpio), .onoff_req_o(reqs[0]), .sleepwake_req_o(reqs[1]),
        .sleep_req_o(reqs[2]), .pwron_req_o(reqs[3]), .wdog_reset_o(reqs[4]),
        .voltage_scale_select_one_o(reqs[5]), .voltage_scale_select_two_o(reqs[6]),
        .hw_enable1_o(reqs[7]), .hw_enable2_o(reqs[8]), .hw_control1_o(reqs[9]),
        .hw_control2_o(reqs[10]), .irq_o(irq_o));
    pgpc_far_end pgpc_far_end_i (.sys_clk_i(sys_clk_i), .drv_en_i(drv_en),
        .drv_val_i(drv_val), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o),
        .pull_down_o(pull_down_o), .pin_i(pin_i));
    // ------
    // tasks
    // ------
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : wt
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        `CHK(rdata_o, e)
    endtask : rd
    task automatic in_case(input int pol, input int code);
        logic [11:0] e;
        e = (RIDX[code] < 0) ? 12'h800 : (12'h1 << RIDX[code]);
        drv_val <= ~pol[0];
        cur = 4'(code);
        wr(16'h403c, 16'h8080 | 16'(pol << 10) | 16'(code));
        wt(70);
        `CHK(obs, 12'h000)
        drv_val <= pol[0];
        wt(20);
        `CHK(obs, (code == 0 || code == 4 || code >= 14) ? 12'h000 : e)
        wt(50);
        `CHK(obs, e)
    endtask : in_case
    task automatic out_case(input int pol, input int code, input logic v);
        logic e;
        e = (code >= 5 && code <= 7) ? 1'b0 : v;
        src <= v ? (16'h1 << code) : ~(16'h1 << code);
        wr(16'h4042, {15'h0, v});
        wt(3);
        `CHK({pin_oe_o, pin_o}, {1'b1, e ~^ pol[0]})
    endtask : out_case
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    // ------
    // tests
    // ------
    initial begin
        wt(6);
        resetn_i <= 1'b1;
        rd(16'h403c, 16'ha400);
        `CHK({pin_oe_o, pull_up_o, pull_down_o}, 3'h0)
        rd(16'h4041, 16'h0000);
        wr(16'h403c, 16'hffff);
        rd(16'h403c, 16'hfe8f);
        `CHK(dom, 1'b1)
        wr(16'h4043, 16'h1234);
        rd(16'h4043, 16'h0000);
        rd(16'h403c, 16'hfe8f);
        wr(16'h403c, 16'hc080);
        wt(2);
        `CHK({pull_up_o, pull_down_o}, 2'h2)
        wr(16'h403c, 16'ha080);
        wt(2);
        `CHK({pull_up_o, pull_down_o, dom}, 3'h2)
        $display("test registers done");
        drv_en <= 1'b1;
        for (int p = 1; p >= 0; p--) for (int c = 0; c < 16; c++) in_case(p, c);
        $display("test inputs done");
        drv_en <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 16; c++) begin
                wr(16'h403c, 16'h0080 | 16'(p << 10) | 16'(c));
                out_case(p, c, 1'b0);
                out_case(p, c, 1'b1);
            end
        end
        wr(16'h403c, 16'h0680);
        wr(16'h4042, 16'h0001);
        wt(3);
        `CHK({pin_oe_o, pin_o}, 2'h0)
        wr(16'h4042, 16'h0000);
        wt(3);
        `CHK({pin_oe_o, pin_o}, 2'h2)
        wr(16'h403c, 16'h0400);
        wt(2);
        `CHK(pin_oe_o, 1'b0)
        $display("test outputs done");
        drv_en <= 1'b1;
        drv_val <= 1'b0;
        wr(16'h403c, 16'h8481);
        wt(30);
        wr(16'h4040, 16'h0003);
        wr(16'h4041, 16'h0001);
        wt(2);
        `CHK(irq_o, 1'b0)
        drv_val <= 1'b1;
        wt(30);
        `CHK(irq_o, 1'b1)
        rd(16'h4040, 16'h0001);
        wr(16'h4040, 16'h0001);
        drv_val <= 1'b0;
        wt(30);
        `CHK(irq_o, 1'b0)
        wr(16'h403c, 16'h9481);
        drv_val <= 1'b1;
        wt(30);
        wr(16'h4040, 16'h0001);
        drv_val <= 1'b0;
        wt(30);
        `CHK(irq_o, 1'b1)
        wr(16'h4041, 16'h0000);
        wt(2);
        `CHK(irq_o, 1'b0)
        rd(16'h4040, 16'h0001);
        wr(16'h4040, 16'h0001);
        wr(16'h4041, 16'h0001);
        wr(16'h403c, 16'h8081);
        drv_val <= 1'b1;
        wt(30);
        `CHK(irq_o, 1'b0)
        drv_val <= 1'b0;
        wt(30);
        `CHK(irq_o, 1'b1)
        wr(16'h403c, 16'h8482);
        wt(30);
        wr(16'h4040, 16'h0003);
        drv_val <= 1'b1;
        wt(30);
        `CHK(reqs[0], 1'b1)
        rd(16'h4040, 16'h0003);
        rd(16'h4042, 16'h0002);
        wr(16'h4041, 16'h0002);
        wt(2);
        `CHK(irq_o, 1'b1)
        $display("test interrupt done");
        clk_en <= 1'b0;
        wr(16'h4041, 16'h0000);
        wt(2);
        `CHK(irq_o, 1'b1)
        clk_en <= 1'b1;
        rd(16'h4041, 16'h0002);
        $display("test freeze done");
        final_report();
    end
    initial begin
        #100000;
        err_total++;
        final_report();
    end
endmodule : tb_pgpc_pin
`default_nettype wire
